// [mss_pkg.sv]
// Constants shared by the multi-step speed sequencer.
// Assumes a 100 MHz core clock and a set-point scale of tenths of a percent.
package mss_pkg;

   // =====================================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS   = 10;
   localparam int unsigned TIME_TENTH_NS   = 100_000_000;
   localparam int unsigned TENTH_CYCLES    = TIME_TENTH_NS / CLK_PERIOD_NS;
   localparam int unsigned TENTHS_PER_HOUR = 3600;

   // =====================================================================
   // Set-point and duration limits
   localparam logic signed [10:0] SP_MAX    = 11'sh3E8;
   localparam logic signed [10:0] SP_MIN    = -11'sh3E8;
   localparam logic        [25:0] PCT_FULL  = 26'h00003E8;
   localparam logic        [15:0] TIME_MAX  = 16'hFDE8;
   localparam logic        [3:0]  LAST_STEP = 4'hF;

   // =====================================================================
   // End-of-cycle modes
   localparam logic [1:0] END_STOP   = 2'h0;
   localparam logic [1:0] END_KEEP   = 2'h1;
   localparam logic [1:0] END_REPEAT = 2'h2;

   // =====================================================================
   // Output target and step 0 sources
   localparam logic [1:0] TGT_FREQ = 2'h0;
   localparam logic [1:0] TGT_VOLT = 2'h1;
   localparam logic [1:0] TGT_PID  = 2'h2;

   localparam logic [2:0] SRC_STORED = 3'h0;
   localparam logic [2:0] SRC_AN_ONE = 3'h1;
   localparam logic [2:0] SRC_AN_TWO = 3'h2;
   localparam logic [2:0] SRC_AN_THR = 3'h3;
   localparam logic [2:0] SRC_PULSE  = 3'h4;
   localparam logic [2:0] SRC_PID    = 3'h5;
   localparam logic [2:0] SRC_KEYPAD = 3'h6;

   typedef enum logic [2:0] {
      S_IDLE = 3'h1,
      S_RUN  = 3'h2,
      S_HOLD = 3'h4
   } mss_state_type;

endpackage : mss_pkg

// [mss_sequencer.sv]
// Multi-step speed sequencer: sixteen stored relative set-points run in order.
// Assumes command and terminal inputs are synchronous to clk.
// What this block does
// - In end mode 0 the drive halts after one full pass and waits for a new start.
// - In end mode 1 the last step's frequency and direction are held after one pass.
// - In end mode 2 the sequence restarts at step 0 after each pass until stopped.
// - As frequency reference, a negative set-point commands reverse rotation.
// - With power retention on, position is saved at power failure and resumed after.
// - With stop retention on, position is saved at stop and resumed at next start.
// - Each set-point is signed, limited to -100.0 to +100.0 percent in tenths.
// - Set-points scale to maximum frequency, rated voltage, or pass to PID unchanged.
// - Terminal states picked by the external controller select the active set-point.
// - Each step runs for its own duration of 0 to 6500.0 units in tenths.
// - Each step carries a two-bit choice of acceleration/deceleration time set.
// - One selector makes all durations count in seconds or in hours.
// - Step 0 takes its value from a selectable source.
// - The output serves as frequency reference or separated voltage reference.
module mss_sequencer
   import mss_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = TENTH_CYCLES,
   parameter int unsigned HOUR_TICKS  = TENTHS_PER_HOUR
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset,
   // Commands
   input  wire logic               start_cmd,
   input  wire logic               stop_cmd,
   input  wire logic               power_fail,
   // Configuration
   input  wire logic [1:0]         end_mode,
   input  wire logic               retain_power,
   input  wire logic               retain_stop,
   input  wire logic               time_unit_hours,
   input  wire logic [1:0]         output_target,
   input  wire logic [2:0]         step0_source,
   input  wire logic [15:0]        max_freq,
   input  wire logic [15:0]        rated_voltage,
   // Step table write
   input  wire logic               cfg_write,
   input  wire logic [3:0]         cfg_index,
   input  wire logic signed [10:0] cfg_setpoint,
   input  wire logic [15:0]        cfg_run_time,
   input  wire logic [1:0]         cfg_accel_sel,
   // Step 0 sources
   input  wire logic signed [10:0] analog_input_one,
   input  wire logic signed [10:0] analog_input_two,
   input  wire logic signed [10:0] analog_input_three,
   input  wire logic signed [10:0] pulse_setting,
   input  wire logic signed [10:0] pid_output,
   input  wire logic signed [10:0] keypad_setting,
   // Terminal selection
   input  wire logic               terminal_select,
   input  wire logic [3:0]         terminal_index,
   // References out
   output logic [15:0]             freq_ref,
   output logic                    reverse,
   output logic [15:0]             volt_ref,
   output logic signed [10:0]      pid_ref,
   output logic [1:0]              accel_set,
   output logic [3:0]              active_step,
   output logic                    running,
   output logic                    cycle_done
);

   typedef struct packed {
      mss_state_type          state;
      logic [3:0]             step;
      logic [15:0]            elapsed;
      logic [31:0]            prescale;
      logic [31:0]            hour_cnt;
      logic [3:0]             saved_step;
      logic [15:0]            saved_elapsed;
      logic                   saved_power;
      logic                   saved_stop;
      logic [15:0][10:0]      setpoint;
      logic [15:0][15:0]      run_time;
      logic [15:0][1:0]       accel;
      logic [15:0]            freq_ref;
      logic                   reverse;
      logic [15:0]            volt_ref;
      logic signed [10:0]     pid_ref;
      logic [1:0]             accel_set;
      logic [3:0]             active_step;
      logic                   running;
      logic                   cycle_done;
   } mss_regs_type;

   mss_regs_type       r;
   mss_regs_type       next_r;
   logic [3:0]         sel_index;
   logic signed [10:0] sel_value;
   logic signed [10:0] raw_value;
   logic [10:0]        magnitude;
   logic               unit_tick;
   logic               step_done;
   logic               pass_end;

   // =====================================================================
   // Set-point selection
   always_comb begin
      sel_index = terminal_select ? terminal_index : r.step;
      raw_value = $signed(r.setpoint[sel_index]);
      if (sel_index == 4'h0) begin
         case (step0_source)
            SRC_AN_ONE: raw_value = analog_input_one;
            SRC_AN_TWO: raw_value = analog_input_two;
            SRC_AN_THR: raw_value = analog_input_three;
            SRC_PULSE:  raw_value = pulse_setting;
            SRC_PID:    raw_value = pid_output;
            SRC_KEYPAD: raw_value = keypad_setting;
            default:    raw_value = $signed(r.setpoint[0]);
         endcase
      end
      if (raw_value > SP_MAX) begin
         sel_value = SP_MAX;
      end else if (raw_value < SP_MIN) begin
         sel_value = SP_MIN;
      end else begin
         sel_value = raw_value;
      end
      magnitude = sel_value[10] ? 11'(-sel_value) : 11'(sel_value);
   end

   // =====================================================================
   // Step timing
   // step duration check
   assign step_done = r.elapsed >= r.run_time[r.step];
   assign pass_end  = (r.state == S_RUN) && step_done && (r.step == LAST_STEP)
                      && !power_fail && !stop_cmd;

   assign unit_tick = (r.prescale == 32'(TICK_CYCLES - 1))
                      && (!time_unit_hours || r.hour_cnt == 32'(HOUR_TICKS - 1));

   always_comb begin
      next_r            = r;
      next_r.cycle_done = 1'b0;

      if (cfg_write) begin
         if (cfg_setpoint > SP_MAX) begin
            next_r.setpoint[cfg_index] = SP_MAX;
         end else if (cfg_setpoint < SP_MIN) begin
            next_r.setpoint[cfg_index] = SP_MIN;
         end else begin
            next_r.setpoint[cfg_index] = cfg_setpoint;
         end
         next_r.run_time[cfg_index] = (cfg_run_time > TIME_MAX) ? TIME_MAX : cfg_run_time;
         next_r.accel[cfg_index] = cfg_accel_sel;
      end

      if (r.state == S_RUN) begin
         if (r.prescale == 32'(TICK_CYCLES - 1)) begin
            next_r.prescale = 32'h0;
            if (r.hour_cnt == 32'(HOUR_TICKS - 1) || !time_unit_hours) begin
               next_r.hour_cnt = 32'h0;
            end else begin
               next_r.hour_cnt = r.hour_cnt + 32'h1;
            end
         end else begin
            next_r.prescale = r.prescale + 32'h1;
         end
         if (unit_tick && !step_done) begin
            next_r.elapsed = r.elapsed + 16'h1;
         end
      end

      case (r.state)
         S_IDLE: begin
            if (start_cmd && !stop_cmd && !power_fail) begin
               next_r.state    = S_RUN;
               next_r.prescale = 32'h0;
               next_r.hour_cnt = 32'h0;
               if ((r.saved_power && retain_power) || (r.saved_stop && retain_stop)) begin
                  next_r.step    = r.saved_step;
                  next_r.elapsed = r.saved_elapsed;
               end else begin
                  next_r.step    = 4'h0;
                  next_r.elapsed = 16'h0;
               end
               next_r.saved_power = 1'b0;
               next_r.saved_stop  = 1'b0;
            end
         end
         S_RUN, S_HOLD: begin
            if (power_fail || stop_cmd) begin
               next_r.state         = S_IDLE;
               next_r.saved_step    = r.step;
               next_r.saved_elapsed = r.elapsed;
               next_r.saved_power   = power_fail;
               next_r.saved_stop    = !power_fail;
            end else if (r.state == S_RUN && step_done) begin
               next_r.elapsed  = 16'h0;
               next_r.prescale = 32'h0;
               next_r.hour_cnt = 32'h0;
               if (r.step != LAST_STEP) begin
                  next_r.step = r.step + 4'h1;
               end else begin
                  next_r.cycle_done = 1'b1;
                  case (end_mode)
                     END_KEEP:   next_r.state = S_HOLD;
                     END_REPEAT: next_r.step = 4'h0;
                     default:    next_r.state = S_IDLE;
                  endcase
               end
            end
         end
         default: next_r.state = S_IDLE;
      endcase

      // Outputs lag the state by one clock; a halted drive shows zero references.
      next_r.running     = (r.state != S_IDLE);
      next_r.active_step = sel_index;
      next_r.accel_set   = r.accel[sel_index];
      next_r.freq_ref    = 16'h0;
      next_r.reverse     = 1'b0;
      next_r.volt_ref    = 16'h0;
      next_r.pid_ref     = 11'sh000;
      if (r.state != S_IDLE) begin
         case (output_target)
            TGT_FREQ: begin
               next_r.freq_ref = 16'((26'(magnitude) * 26'(max_freq)) / PCT_FULL);
               next_r.reverse  = sel_value[10];
            end
            TGT_VOLT: next_r.volt_ref = 16'((26'(magnitude) * 26'(rated_voltage)) / PCT_FULL);
            TGT_PID:  next_r.pid_ref  = sel_value;
            default:  next_r.pid_ref  = 11'sh000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r       <= '0;
         r.state <= S_IDLE;
      end else begin
         r <= next_r;
      end
   end

   assign freq_ref    = r.freq_ref;
   assign reverse     = r.reverse;
   assign volt_ref    = r.volt_ref;
   assign pid_ref     = r.pid_ref;
   assign accel_set   = r.accel_set;
   assign active_step = r.active_step;
   assign running     = r.running;
   assign cycle_done  = r.cycle_done;

   // =====================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_mode0_halt: assert property (pass_end && end_mode == END_STOP |=>
      r.state == S_IDLE && cycle_done ##1 !running) else $error("mode 0 did not halt");
   a_mode1_hold: assert property (pass_end && end_mode == END_KEEP |=>
      r.state == S_HOLD && r.step == LAST_STEP) else $error("mode 1 did not hold");
   a_mode2_wrap: assert property (pass_end && end_mode == END_REPEAT |=>
      r.state == S_RUN && r.step == 4'h0) else $error("mode 2 did not wrap");
   a_dir_sign: assert property (r.state != S_IDLE && output_target == TGT_FREQ
      |=> reverse == $past(sel_value[10])) else $error("direction mismatch");
   a_power_save: assert property ((r.state != S_IDLE) && power_fail |=>
      r.saved_power && r.saved_step == $past(r.step)) else $error("power snapshot lost");
   a_stop_save: assert property ((r.state != S_IDLE) && stop_cmd && !power_fail |=>
      r.saved_stop && r.saved_elapsed == $past(r.elapsed)) else $error("stop snapshot lost");
   a_pid_limit: assert property (pid_ref <= SP_MAX && pid_ref >= SP_MIN)
      else $error("set-point out of span");
   a_step_dwell: assert property (r.state == S_RUN && !step_done && !stop_cmd
      && !power_fail |=> r.step == $past(r.step)) else $error("step left early");
   a_step_order: assert property (r.state == S_RUN && step_done && r.step != LAST_STEP
      && !stop_cmd && !power_fail |=> r.step == $past(r.step) + 4'h1 && r.elapsed == 16'h0)
      else $error("step order broken");

   c_repeat_pass: cover property (pass_end && end_mode == END_REPEAT);
   c_keep_pass:   cover property (pass_end && end_mode == END_KEEP ##1 r.state == S_HOLD);
   c_resume_stop: cover property (r.saved_stop && retain_stop && start_cmd
      && r.saved_step != 4'h0);

endmodule : mss_sequencer

// [mss_far_side.sv]
// Far-side model: the external controller's terminal lines and step 0 sources.
// Assumes the bench hands it a terminal request synchronous to clk.
module mss_far_side
   import mss_pkg::*;
(
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               reset,
   // Requested terminal state, bit 4 selects
   input  wire logic [4:0]         pick,
   // Terminal lines
   output logic                    terminal_select,
   output logic [3:0]              terminal_index,
   // Step 0 sources
   output logic signed [10:0]      analog_input_one,
   output logic signed [10:0]      analog_input_two,
   output logic signed [10:0]      analog_input_three,
   output logic signed [10:0]      pulse_setting,
   output logic signed [10:0]      pid_output,
   output logic signed [10:0]      keypad_setting
);
   // =====================================================================
   // terminal state drive
   always_ff @(posedge clk) begin
      if (reset) begin
         terminal_select <= 1'b0;
         terminal_index  <= 4'h0;
      end else begin
         terminal_select <= pick[4];
         terminal_index  <= pick[3:0];
      end
   end
   // Distinct values, so that a wrong source choice cannot match by chance.
   assign analog_input_one   = 11'sh064;
   assign analog_input_two   = -11'sh0C8;
   assign analog_input_three = 11'sh12C;
   assign pulse_setting      = 11'sh190;
   assign pid_output         = -11'sh1F4;
   assign keypad_setting     = 11'sh258;
endmodule : mss_far_side

// [mss_sequencer_tb.sv]
// Self-checking bench for the multi-step speed sequencer.
// Assumes shortened tick counts: 4 cycles a tenth, 3 tenths an hour.
module mss_sequencer_tb
   import mss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 4;
   localparam int HOURS = 3;
   logic clk;
   logic reset = 1'b1;
   logic start_cmd = 1'b0, stop_cmd = 1'b0, power_fail = 1'b0, cfg_write = 1'b0;
   logic retain_power = 1'b0, retain_stop = 1'b0, time_unit_hours = 1'b0;
   logic [1:0] end_mode = 2'h0, output_target = 2'h0, cfg_accel_sel = 2'h0;
   logic [2:0] step0_source = 3'h0;
   logic [3:0] cfg_index = 4'h0;
   logic [15:0] max_freq = 16'h07D0, rated_voltage = 16'h01F4, cfg_run_time = 16'h0000;
   logic signed [10:0] cfg_setpoint = 11'sh000;
   logic signed [10:0] analog_input_one, analog_input_two, analog_input_three;
   logic signed [10:0] pulse_setting, pid_output, keypad_setting, pid_ref;
   logic terminal_select, running, cycle_done, reverse;
   logic done_seen = 1'b0;
   logic [3:0] terminal_index, active_step;
   logic [4:0] pick = 5'h00;
   logic [15:0] freq_ref, volt_ref;
   logic [1:0] accel_set;
   int err_count = 0, checks = 0;
   int src_exp [7] = '{450, 100, -200, 300, 400, -500, 600};

   mss_sequencer #(.TICK_CYCLES(TICK), .HOUR_TICKS(HOURS)) u_dut (.*);
   mss_far_side u_far (.*);

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) if (cycle_done === 1'b1) done_seen <= 1'b1;

   // =====================================================================
   // Shared tasks
   task automatic stop_test;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // Polls at falling edges; a wait that runs out ends the run.
   task automatic wait_step(input logic [3:0] idx, input logic run);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (!(active_step === idx && running === run) && n < 400);
      check("step and running", {11'h0, run, idx}, {11'h0, running, active_step});
      if (n == 400) stop_test();
   endtask : wait_step

   task automatic cmd(input logic [2:0] c);
      @(posedge clk);
      {power_fail, stop_cmd, start_cmd} <= c;
      @(posedge clk);
      {power_fail, stop_cmd, start_cmd} <= 3'h0;
   endtask : cmd

   task automatic write_step(input logic [3:0] i, input logic signed [10:0] sp,
                             input logic [15:0] rt, input logic [1:0] acc);
      @(posedge clk);
      cfg_write <= 1'b1;
      cfg_index <= i;
      cfg_setpoint <= sp;
      cfg_run_time <= rt;
      cfg_accel_sel <= acc;
      @(posedge clk);
      cfg_write <= 1'b0;
   endtask : write_step

   // One full pass; step k holds 450 - 50k tenths of a percent.
   task automatic run_pass(input int dur);
      int sp;
      int n;
      for (int k = 0; k < 16; k++) begin
         sp = 450 - 50 * k;
         wait_step(4'(k), 1'b1);
         check("freq_ref", 16'((sp < 0 ? -sp : sp) * 2), freq_ref);
         check("reverse", {15'h0, sp < 0}, {15'h0, reverse});
         check("accel_set", 16'(k % 4), {14'h0, accel_set});
         if (k == 3) begin
            n = 0;
            while (active_step === 4'h3 && n < 99) begin
               @(negedge clk);
               n++;
            end
            check("step 3 cycles", 16'(dur), 16'(n));
         end
      end
   endtask : run_pass

   // =====================================================================
   // Main sequence
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      for (int k = 0; k < 16; k++) begin
         write_step(4'(k), 11'(450 - 50 * k), (k == 3) ? 16'h0002 : 16'h0001, 2'(k));
      end
      cmd(3'h1);
      run_pass(2 * TICK + 1);
      wait_step(4'hF, 1'b0);
      check("cycle_done seen", 16'h0001, {15'h0, done_seen});
      repeat (20) @(negedge clk);
      check("running", 16'h0000, {15'h0, running});
      @(posedge clk);
      time_unit_hours <= 1'b1;
      end_mode <= END_KEEP;
      cmd(3'h1);
      run_pass(2 * TICK * HOURS + 1);
      repeat (40) @(negedge clk);
      wait_step(4'hF, 1'b1);
      check("freq_ref", 16'h0258, freq_ref);
      check("reverse", 16'h0001, {15'h0, reverse});
      @(posedge clk);
      output_target <= TGT_VOLT;
      repeat (3) @(negedge clk);
      check("volt_ref", 16'h0096, volt_ref);
      check("freq_ref", 16'h0000, freq_ref);
      @(posedge clk);
      output_target <= TGT_PID;
      repeat (3) @(negedge clk);
      check("pid_ref", 16'hFED4, 16'($signed(pid_ref)));
      write_step(4'hE, 11'sh3F0, 16'h0001, 2'h2);
      @(posedge clk);
      output_target <= TGT_FREQ;
      pick <= 5'h1E;
      repeat (4) @(negedge clk);
      check("active_step", 16'h000E, {12'h0, active_step});
      check("freq_ref", 16'h07D0, freq_ref);
      check("accel_set", 16'h0002, {14'h0, accel_set});
      @(posedge clk);
      output_target <= TGT_PID;
      pick <= 5'h10;
      for (int s = 0; s < 7; s++) begin
         @(posedge clk);
         step0_source <= 3'(s);
         repeat (4) @(negedge clk);
         check("pid_ref", 16'(src_exp[s]), 16'($signed(pid_ref)));
      end
      @(posedge clk);
      step0_source <= SRC_STORED;
      pick <= 5'h00;
      output_target <= TGT_FREQ;
      time_unit_hours <= 1'b0;
      end_mode <= END_REPEAT;
      cmd(3'h2);
      // A halted sequencer keeps showing the step it stopped on.
      wait_step(4'hF, 1'b0);
      // Stop then power failure, each without and with retention.
      for (int c = 0; c < 4; c++) begin
         @(posedge clk);
         retain_stop <= c[0];
         retain_power <= c[0];
         cmd(3'h1);
         wait_step(4'hF, 1'b1);
         wait_step(4'h0, 1'b1);
         wait_step(4'h5, 1'b1);
         cmd(c[1] ? 3'h4 : 3'h2);
         wait_step(4'h5, 1'b0);
         cmd(3'h1);
         repeat (2) @(negedge clk);
         check("resumed step", c[0] ? 16'h0005 : 16'h0000, {12'h0, active_step});
         cmd(3'h2);
         wait_step(c[0] ? 4'h5 : 4'h0, 1'b0);
      end
      stop_test();
   end
endmodule : mss_sequencer_tb
